// ==== design/route_ctrl_pkg.sv ====
package route_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CONV01_ROUTE_SELECT_OFS = 8'hc3;
  localparam logic [7:0] ROUTE_ENABLE_CONV2_SELECT_OFS = 8'hc4;
  localparam logic [7:0] CONV3_ROUTE_SELECT_OFS = 8'hf3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CONV0_FIELD_LSB = 0;
  localparam int CONV1_FIELD_LSB = 4;
  localparam int CONV2_FIELD_LSB = 0;
  localparam int CONV3_FIELD_LSB = 4;
  localparam int MANUAL_ENABLE_BIT = 7;
  localparam int FIELD_WIDTH = 4;

  // Reset values are not defined for the part; zero keeps all switches open
  localparam logic [7:0] CONV01_ROUTE_SELECT_RST = 8'h00;
  localparam logic [7:0] ROUTE_ENABLE_CONV2_SELECT_RST = 8'h00;
  localparam logic [7:0] CONV3_ROUTE_SELECT_RST = 8'h00;

  // Writable bits; the others read as zero
  localparam logic [7:0] ROUTE_ENABLE_CONV2_SELECT_MASK = 8'h8f;
  localparam logic [7:0] CONV3_ROUTE_SELECT_MASK = 8'hf0;

  // ----------------------------------------------------------------
  // Select codes and channel layout
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_CH1 = 4'h1;
  localparam logic [3:0] SEL_CH2 = 4'h2;
  localparam logic [3:0] SEL_CH4 = 4'h4;
  localparam logic [3:0] SEL_CH5 = 4'h5;
  localparam logic [3:0] SEL_CH6 = 4'h6;
  localparam logic [3:0] SEL_CH3 = 4'hc;
  localparam int NUM_CHANNELS = 6;
  localparam int NUM_CONVERTERS = 4;

  // Bit n of the result closes the switch of analog input channel n+1
  function automatic logic [5:0] route_decode(input int conv, input logic [3:0] code);
    logic [5:0] sw;
    sw = 6'h00;
    case (code)
      SEL_CH1: sw = (conv == 0) ? 6'h01 : 6'h00;
      SEL_CH2: sw = (conv == 0 || conv == 2) ? 6'h02 : 6'h00;
      SEL_CH4: sw = 6'h08;
      SEL_CH5: sw = (conv != 3) ? 6'h10 : 6'h00;
      SEL_CH6: sw = (conv != 3) ? 6'h20 : 6'h00;
      SEL_CH3: sw = (conv == 0 || conv == 1) ? 6'h04 : 6'h00;
      default: sw = 6'h00;
    endcase
    return sw;
  endfunction : route_decode

endpackage : route_ctrl_pkg

// ==== design/conv_switch_drive.sv ====
`timescale 1ns/10ps
`default_nettype none
module conv_switch_drive import route_ctrl_pkg::*; #(
  parameter int CONV = 0
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic route_en,
  input wire logic [3:0] route_field,
  output logic [5:0] switch_q,
  output logic connected_q
);

  // ----------------------------------------------------------------
  // Switch decode
  // ----------------------------------------------------------------
  wire logic [5:0] switch_d;
  wire logic [5:0] decoded;

  generate
    if (CONV < 0 || CONV >= NUM_CONVERTERS) begin : g_bad_conv
      $error("conv_switch_drive: converter index out of range");
    end
  endgenerate

  assign decoded = route_decode(CONV, route_field);
  // R9: gate when disabled
  assign switch_d = route_en ? decoded : 6'h00;

  // Registered so the analog switch lines never glitch on a field write
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      switch_q <= 6'h00;
      connected_q <= 1'b0;
    end else if (ce) begin
      switch_q <= switch_d;
      connected_q <= |switch_d;
    end
  end

endmodule : conv_switch_drive
`default_nettype wire

// ==== design/adc_input_route_control.sv ====
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1: Input routing is always driven from software-programmed select fields, never automatically.
// R2: Bit 7 of the register at offset c4 is the manual routing enable that hands the switches to the fields.
// R3: Only the analog switches are affected; format and standard selection stay with other blocks.
// R4: Converter 0 field c3[3:0] connects channel 1,2,4,5,6,3 for codes 1,2,4,5,6,c.
// R5: Converter 1 field c3[7:4] connects channel 4,5,6,3 for codes 4,5,6,c; codes 1 and 2 connect nothing.
// R6: Converter 2 field c4[3:0] connects channel 2,4,5,6 for codes 2,4,5,6; codes 1 and c connect nothing.
// R7: Converter 3 field f3[7:4] connects only channel 4 with code 4.
// R8: Software must only program channel and converter pairs that the routing can reach.
// R9: With the enable clear, field values are kept but no switch is closed.
module adc_input_route_control import route_ctrl_pkg::*; #(
  parameter int CHANNELS = NUM_CHANNELS,
  parameter int CONVERTERS = NUM_CONVERTERS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic manual_route_enable,
  output logic [5:0] conv0_switch,
  output logic [5:0] conv1_switch,
  output logic [5:0] conv2_switch,
  output logic [5:0] conv3_switch,
  output logic [3:0] conv_connected
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (CHANNELS != NUM_CHANNELS || CONVERTERS != NUM_CONVERTERS) begin : g_bad_size
      $error("adc_input_route_control: only six channels and four converters are wired");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] conv01_route_select_q;
  logic [7:0] route_enable_conv2_select_q;
  logic [7:0] conv3_route_select_q;
  logic [7:0] reg_rdata_q;
  logic reg_rvalid_q;

  wire logic hit_c3;
  wire logic hit_c4;
  wire logic hit_f3;
  wire logic [7:0] rd_mux;

  assign hit_c3 = (reg_addr == CONV01_ROUTE_SELECT_OFS);
  assign hit_c4 = (reg_addr == ROUTE_ENABLE_CONV2_SELECT_OFS);
  assign hit_f3 = (reg_addr == CONV3_ROUTE_SELECT_OFS);

  // Unmapped addresses read as zero and ignore writes
  assign rd_mux = hit_c3 ? conv01_route_select_q :
                  hit_c4 ? route_enable_conv2_select_q :
                  hit_f3 ? conv3_route_select_q : 8'h00;

  // R1: software-owned select fields
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      conv01_route_select_q <= CONV01_ROUTE_SELECT_RST;
    end else if (ce && reg_wr && hit_c3) begin
      conv01_route_select_q <= reg_wdata;
    end
  end

  // R2: enable bit shares c4 with converter 2
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      route_enable_conv2_select_q <= ROUTE_ENABLE_CONV2_SELECT_RST;
    end else if (ce && reg_wr && hit_c4) begin
      route_enable_conv2_select_q <= reg_wdata & ROUTE_ENABLE_CONV2_SELECT_MASK;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      conv3_route_select_q <= CONV3_ROUTE_SELECT_RST;
    end else if (ce && reg_wr && hit_f3) begin
      conv3_route_select_q <= reg_wdata & CONV3_ROUTE_SELECT_MASK;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else if (ce) begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign reg_rvalid = reg_rvalid_q;

  // ----------------------------------------------------------------
  // Switch control
  // ----------------------------------------------------------------
  wire logic route_en;
  wire logic [3:0] conv0_route_field;
  wire logic [3:0] conv1_route_field;
  wire logic [3:0] conv2_route_field;
  wire logic [3:0] conv3_route_field;
  wire logic [3:0] field_arr [NUM_CONVERTERS];
  wire logic [5:0] switch_arr [NUM_CONVERTERS];
  wire logic [3:0] conn_w;

  // R2: manual enable bit
  assign route_en = route_enable_conv2_select_q[MANUAL_ENABLE_BIT];
  assign conv0_route_field = conv01_route_select_q[CONV0_FIELD_LSB +: FIELD_WIDTH];
  assign conv1_route_field = conv01_route_select_q[CONV1_FIELD_LSB +: FIELD_WIDTH];
  assign conv2_route_field = route_enable_conv2_select_q[CONV2_FIELD_LSB +: FIELD_WIDTH];
  assign conv3_route_field = conv3_route_select_q[CONV3_FIELD_LSB +: FIELD_WIDTH];
  assign field_arr[0] = conv0_route_field;
  assign field_arr[1] = conv1_route_field;
  assign field_arr[2] = conv2_route_field;
  assign field_arr[3] = conv3_route_field;

  // R3: nothing here touches format or standard selection
  // R8: unreachable pairs simply leave the converter open
  generate
    for (genvar g = 0; g < NUM_CONVERTERS; g++) begin : g_conv
      conv_switch_drive #(
        .CONV(g)
      ) u_drive (
        .mclk(mclk),
        .nrst(nrst),
        .ce(ce),
        .route_en(route_en),
        .route_field(field_arr[g]),
        .switch_q(switch_arr[g]),
        .connected_q(conn_w[g])
      );
    end
  endgenerate

  assign manual_route_enable = route_en;
  assign conv_connected = conn_w;
  assign conv0_switch = switch_arr[0];
  assign conv1_switch = switch_arr[1];
  assign conv2_switch = switch_arr[2];
  assign conv3_switch = switch_arr[3];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  wire logic upd;
  assign upd = ce && route_en;

  // R2: enable bit follows writes to c4
  a_enable_write: assert property (
    ce && reg_wr && hit_c4 |=> manual_route_enable == $past(reg_wdata[MANUAL_ENABLE_BIT]))
    else $error("enable bit not taken from write");

  // R9: disabled leaves switches open
  a_disabled_open: assert property (ce && !route_en |=> conv_connected == 4'h0 &&
    conv0_switch == 6'h00 && conv1_switch == 6'h00 && conv2_switch == 6'h00 &&
    conv3_switch == 6'h00) // R9
    else $error("switch closed while manual routing is off");

  // R9: c3 fields kept while disabled
  a_field_kept: assert property (
    !route_en && !(ce && reg_wr && hit_c3) |=> $stable(conv01_route_select_q)) // R9
    else $error("select field lost while disabled");

  // R4: converter 0 map
  a_conv0_map: assert property (upd |=> conv0_switch ==
    (($past(conv0_route_field) == SEL_CH1) ? 6'h01 :
     ($past(conv0_route_field) == SEL_CH2) ? 6'h02 :
     ($past(conv0_route_field) == SEL_CH4) ? 6'h08 :
     ($past(conv0_route_field) == SEL_CH5) ? 6'h10 :
     ($past(conv0_route_field) == SEL_CH6) ? 6'h20 :
     ($past(conv0_route_field) == SEL_CH3) ? 6'h04 : 6'h00)) // R4
    else $error("converter 0 routing wrong");

  // R5: converter 1 channel 3 and no 1 or 2
  a_conv1_ch3: assert property (upd && conv1_route_field == SEL_CH3 |=>
    conv1_switch == 6'h04) // R5
    else $error("converter 1 code c not channel 3");
  a_conv1_none: assert property (upd && (conv1_route_field == SEL_CH1 ||
    conv1_route_field == SEL_CH2) |=> conv1_switch == 6'h00 && !conv_connected[1]) // R5
    else $error("converter 1 connected on unsupported code");

  // R6: converter 2 channel 2 and no code c
  a_conv2_ch2: assert property (upd && conv2_route_field == SEL_CH2 |=>
    conv2_switch == 6'h02 && conv_connected[2]) // R6
    else $error("converter 2 code 2 not channel 2");
  a_conv2_none: assert property (upd && (conv2_route_field == SEL_CH3 ||
    conv2_route_field == SEL_CH1) |=> conv2_switch == 6'h00) // R6
    else $error("converter 2 connected on unsupported code");

  // R7: converter 3 only channel 4
  a_conv3_only4: assert property (ce |=> conv3_switch == 6'h00 ||
    (conv3_switch == 6'h08 && $past(conv3_route_field) == SEL_CH4)) // R7
    else $error("converter 3 connected to other than channel 4");

  // R1: one switch at most per converter, read back matches
  a_one_hot: assert property ($onehot0(conv0_switch) && $onehot0(conv1_switch) &&
    $onehot0(conv2_switch) && $onehot0(conv3_switch)) // R1
    else $error("more than one switch closed on a converter");
  a_readback: assert property (ce && reg_rd && hit_c3 && !reg_wr |=>
    reg_rvalid && reg_rdata == conv01_route_select_q) // R1
    else $error("read back differs from stored route");

endmodule : adc_input_route_control
`default_nettype wire

// ==== tb/adc_input_route_control_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module adc_input_route_control_tb;
  import route_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Clock, reset and design
  // ----------------------------------------------------------------
  logic mclk, nrst, ce, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata;
  wire logic [7:0] reg_rdata;
  wire logic reg_rvalid, manual_route_enable;
  wire logic [5:0] conv0_switch, conv1_switch, conv2_switch, conv3_switch;
  wire logic [3:0] conv_connected;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;

  typedef struct packed {
    logic [3:0] code;
    logic [5:0] s0, s1, s2, s3;
  } row_t;

  // Same code in every field at once, so one row exercises all four converters
  row_t rows [8] = '{
    '{4'h1, 6'h01, 6'h00, 6'h00, 6'h00}, '{4'h2, 6'h02, 6'h00, 6'h02, 6'h00},
    '{4'h4, 6'h08, 6'h08, 6'h08, 6'h08}, '{4'h5, 6'h10, 6'h10, 6'h10, 6'h00},
    '{4'h6, 6'h20, 6'h20, 6'h20, 6'h00}, '{4'hc, 6'h04, 6'h04, 6'h00, 6'h00},
    '{4'h0, 6'h00, 6'h00, 6'h00, 6'h00}, '{4'hf, 6'h00, 6'h00, 6'h00, 6'h00}};

  adc_input_route_control DUT (
    .mclk(mclk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .manual_route_enable(manual_route_enable), .conv0_switch(conv0_switch),
    .conv1_switch(conv1_switch), .conv2_switch(conv2_switch), .conv3_switch(conv3_switch),
    .conv_connected(conv_connected)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Idle cycle after the strobe gives the switches their one-cycle lag
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    @(posedge mclk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    check("rvalid", {7'h00, reg_rvalid}, 8'h01);
    check("rdata", reg_rdata, exp);
    @(posedge mclk);
    #1;
    check("rvalid low", {7'h00, reg_rvalid}, 8'h00);
  endtask : rd

  task automatic sw_chk(input logic [5:0] s0, s1, s2, s3);
    check("conv0", {2'b00, conv0_switch}, {2'b00, s0});
    check("conv1", {2'b00, conv1_switch}, {2'b00, s1});
    check("conv2", {2'b00, conv2_switch}, {2'b00, s2});
    check("conv3", {2'b00, conv3_switch}, {2'b00, s3});
    check("connected", {4'h0, conv_connected}, {4'h0, |s3, |s2, |s1, |s0});
  endtask : sw_chk

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard, well above the hundred or so cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (5) @(posedge mclk);
    #1;
    check("enable at reset", {7'h00, manual_route_enable}, 8'h00);
    sw_chk(6'h00, 6'h00, 6'h00, 6'h00);
    nrst = 1'b1;
    rd(CONV01_ROUTE_SELECT_OFS, 8'h00);
    rd(ROUTE_ENABLE_CONV2_SELECT_OFS, 8'h00);
    rd(CONV3_ROUTE_SELECT_OFS, 8'h00);
    $display("test reset done");
    // the six select codes plus codes 0 and f through the host-programmed fields
    foreach (rows[i]) begin
      wr(CONV01_ROUTE_SELECT_OFS, {rows[i].code, rows[i].code});
      wr(ROUTE_ENABLE_CONV2_SELECT_OFS, {4'h8, rows[i].code});
      wr(CONV3_ROUTE_SELECT_OFS, {rows[i].code, 4'h0});
      check("enable", {7'h00, manual_route_enable}, 8'h01);
      sw_chk(rows[i].s0, rows[i].s1, rows[i].s2, rows[i].s3);
    end
    $display("test decode table done");
    // enable clear keeps fields but opens every switch
    wr(CONV01_ROUTE_SELECT_OFS, 8'h56);
    wr(ROUTE_ENABLE_CONV2_SELECT_OFS, 8'h04);
    check("enable off", {7'h00, manual_route_enable}, 8'h00);
    sw_chk(6'h00, 6'h00, 6'h00, 6'h00);
    rd(CONV01_ROUTE_SELECT_OFS, 8'h56);
    rd(ROUTE_ENABLE_CONV2_SELECT_OFS, 8'h04);
    wr(CONV3_ROUTE_SELECT_OFS, 8'h40);
    wr(ROUTE_ENABLE_CONV2_SELECT_OFS, 8'h84);
    sw_chk(6'h20, 6'h10, 6'h08, 6'h08);
    $display("test enable hold done");
    // Reserved bits read zero, unmapped place answers 00
    wr(ROUTE_ENABLE_CONV2_SELECT_OFS, 8'hff);
    rd(ROUTE_ENABLE_CONV2_SELECT_OFS, 8'h8f);
    wr(CONV3_ROUTE_SELECT_OFS, 8'hff);
    rd(CONV3_ROUTE_SELECT_OFS, 8'hf0);
    wr(8'hc5, 8'h5a);
    rd(8'hc5, 8'h00);
    rd(CONV01_ROUTE_SELECT_OFS, 8'h56);
    $display("test reserved done");
    // Clock enable low must freeze the registers
    ce = 1'b0;
    wr(CONV01_ROUTE_SELECT_OFS, 8'h11);
    ce = 1'b1;
    rd(CONV01_ROUTE_SELECT_OFS, 8'h56);
    $display("test clock enable done");
    // Reset in mid-run clears fields and opens switches
    nrst = 1'b0;
    @(posedge mclk);
    #1;
    check("enable in reset", {7'h00, manual_route_enable}, 8'h00);
    sw_chk(6'h00, 6'h00, 6'h00, 6'h00);
    nrst = 1'b1;
    rd(CONV01_ROUTE_SELECT_OFS, 8'h00);
    rd(ROUTE_ENABLE_CONV2_SELECT_OFS, 8'h00);
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule : adc_input_route_control_tb
`default_nettype wire
